// ### src/usb_ifm_pkg.sv
// package: register map, field positions and reset values of the usb interface machine registers
package usb_ifm_pkg;

  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] OFS_DEV_ADDR = 8'h08;
  localparam logic [7:0] OFS_FUNC_CTRL = 8'h0c;
  localparam logic [7:0] OFS_OTG_CTRL = 8'h10;
  localparam logic [7:0] OFS_OTG_FLAGS = 8'h14;
  localparam logic [7:0] OFS_SERIAL_CTRL = 8'h18;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_STICKY = 8'h20;
  localparam logic [7:0] OFS_PORT_MASKS = 8'h24;
  localparam logic [7:0] OFS_FRAME = 8'h28;
  localparam logic [7:0] OFS_PID = 8'h2c;
  localparam logic [7:0] OFS_ENDPOINT = 8'h30;
  localparam logic [7:0] OFS_EP_MARK = 8'h34;
  localparam logic [7:0] OFS_OTG_MASK = 8'h38;

  // functional control fields
  localparam int FC_OPMODE_LSB = 2;
  localparam int FC_TERMSEL_BIT = 1;
  localparam int FC_XCVRSEL_BIT = 0;
  localparam logic [2:0] FC_OPMODE_RST = 3'h1;
  localparam logic [2:0] OPMODE_DISABLED = 3'h0;
  localparam logic FC_TERMSEL_RST = 1'b1;
  localparam logic FC_XCVRSEL_RST = 1'b1;

  // on-the-go control bit positions
  localparam int OC_EXT_VBUS_IND = 7;
  localparam int OC_EXT_VBUS_DRV = 6;
  localparam int OC_CHRG_VBUS = 4;
  localparam int OC_DISCHRG_VBUS = 3;
  localparam int OC_DM_PULLDOWN = 2;
  localparam int OC_DP_PULLDOWN = 1;
  localparam int OC_ID_PULLUP = 0;
  localparam logic [7:0] OC_WRITABLE = 8'hdf;

  // serial control bit positions
  localparam int SC_RX_RCV = 6;
  localparam int SC_RX_DM = 5;
  localparam int SC_RX_DP = 4;
  localparam int SC_TX_SE0 = 3;
  localparam int SC_TX_DATA = 2;
  localparam int SC_TX_EN_N = 1;
  localparam int SC_FSLS_SERIAL = 0;
  localparam logic SC_TX_EN_N_RST = 1'b1;

  // line event flag bit positions
  localparam int EF_TOKEN_OK = 6;
  localparam int EF_SE0 = 5;
  localparam int EF_K = 4;
  localparam int EF_J = 3;
  localparam int EF_CRC16_ERR = 2;
  localparam int EF_RX_ACTIVE = 1;
  localparam int EF_RX_ERROR = 0;
  localparam int EF_WIDTH = 7;

  // port mask fields
  localparam int PM_A_LSB = 0;
  localparam int PM_B_LSB = 8;
  localparam int PM_C_LSB = 16;

  localparam int EP_VALID_BIT = 4;
  localparam logic [4:0] EP_MARK_OR = 5'h10;

  // utmi line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;

  typedef struct packed {
    logic [2:0] opmode;
    logic term_select;
    logic xcvr_select;
    logic ext_vbus_ind;
    logic ext_vbus_drv;
    logic chrg_vbus;
    logic dischrg_vbus;
    logic dm_pulldown;
    logic dp_pulldown;
    logic id_pullup;
    logic tx_se0;
    logic tx_data;
    logic tx_enable_n;
    logic fsls_serial;
  } phy_ctrl_t;

  typedef struct packed {
    logic bvalid;
    logic id_gnd;
    logic host_disc;
    logic vbus_valid;
    logic sess_valid;
    logic sess_end;
    logic rx_rcv;
    logic rx_dm;
    logic rx_dp;
    logic rx_active;
    logic rx_error;
    logic [1:0] line_state;
  } phy_status_t;

  // packet decode results from the token/data path
  typedef struct packed {
    logic pkt_start;
    logic token_valid;
    logic [6:0] token_addr;
    logic data_crc_err;
    logic pid_valid;
    logic [3:0] pid;
    logic ep_valid;
    logic [3:0] endpoint;
  } pkt_info_t;

endpackage

// ### src/usb_flag_bit.sv
// one line event flag with sticky or auto-clearing behaviour
`timescale 1ns/1ps
`default_nettype none
module usb_flag_bit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_clr_i,
  input wire logic sticky_i,
  input wire logic pkt_start_i,
  input wire logic set_i,
  input wire logic follow_i,
  input wire logic level_i,
  input wire logic w1c_i,
  output logic flag_o
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (sticky_i) begin
      // sticky bit: holds until a one is written, set wins
      if (w1c_i) begin
        flag_next = 1'b0;
      end
      if (set_i || (follow_i && level_i)) begin
        flag_next = 1'b1;
      end
    end else begin
      // normal bit: cleared on next packet, overwritten by signal
      if (pkt_start_i) begin
        flag_next = 1'b0;
      end
      if (follow_i) begin
        flag_next = level_i;
      end else if (set_i) begin
        flag_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || soft_clr_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule
`default_nettype wire

// ### src/usb_ifm_regs.sv
// usb interface machine register set: phy controls, status, event flags and packet info
//
// How it works
// - opmode field resets 1, drives phy opmode
// - bit1 termselect, bit0 xcvrselect, reset 1
// - otg control bits drive phy controls
// - otg flags show live phy status
// - serial bits 6:4 show rx lines
// - serial bits 3,2,0 drive tx controls
// - serial bit1 active-low tx enable, reset 1
// - non-sticky flags 6:2 clear on next packet
// - bit6 set on good addressed token
// - bits 5,4,3 set on SE0,K,J
// - bit2 set on crc16 failure
// - bits 1,0 follow rxactive, rxerror
// - sticky flags hold until one written
// - three masks OR flags onto outputs
// - 11-bit frame register, written and read as bits 10:0
// - capture last packet id
// - last endpoint copy plus valid bit
// - marked endpoint presented ORed with 0x10
// - only own device address tokens pass
// - write to reset register clears state
`timescale 1ns/1ps
`default_nettype none
module usb_ifm_regs (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire usb_ifm_pkg::phy_status_t PHY_STATUS_I,
  input wire usb_ifm_pkg::pkt_info_t PKT_INFO_I,
  output usb_ifm_pkg::phy_ctrl_t PHY_CTRL_O,
  output logic FLAG_OUTPUT_PORT_A_O,
  output logic FLAG_OUTPUT_PORT_B_O,
  output logic FLAG_OUTPUT_PORT_C_O,
  output logic RX_EP_VALID_O,
  output logic [4:0] RX_EP_O
);
  import usb_ifm_pkg::*;

  logic [2:0] opmode_reg;
  logic term_sel_reg;
  logic xcvr_sel_reg;
  logic [7:0] otg_ctrl_reg;
  logic [5:0] otg_flags_reg;
  logic [2:0] rx_lines_reg;
  logic tx_se0_reg;
  logic tx_data_reg;
  logic tx_en_n_reg;
  logic fsls_reg;
  logic [6:0] dev_addr_reg;
  logic [6:0] sticky_reg;
  logic [31:0] port_masks_reg;
  logic [10:0] frame_reg;
  logic [3:0] pid_reg;
  logic [3:0] ep_reg;
  logic ep_valid_reg;
  logic [15:0] ep_mark_reg;
  logic [31:0] otg_mask_reg;
  logic [6:0] flags;
  logic [6:0] flag_set;
  logic [6:0] flag_follow;
  logic [6:0] flag_level;
  logic soft_clr;
  logic token_match;
  logic [31:0] rdata_next;
  logic port_a_reg;
  logic port_b_reg;
  logic port_c_reg;
  logic rx_ep_valid_reg;
  logic [4:0] rx_ep_reg;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = REG_WR_I && (REG_ADDR_I == ofs);
  endfunction

  function automatic logic mask_any(input logic [31:0] masks, input int lsb,
                                    input logic [6:0] f);
    logic [7:0] m;
    m = masks[lsb +: 8];
    mask_any = |(m[6:0] & f);
  endfunction

  assign soft_clr = wr_hit(OFS_RESET);

  assign token_match = PKT_INFO_I.token_valid && (PKT_INFO_I.token_addr == dev_addr_reg);

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      opmode_reg <= FC_OPMODE_RST;
      term_sel_reg <= FC_TERMSEL_RST;
      xcvr_sel_reg <= FC_XCVRSEL_RST;
    end else if (wr_hit(OFS_FUNC_CTRL)) begin
      opmode_reg <= REG_WDATA_I[FC_OPMODE_LSB +: 3];
      term_sel_reg <= REG_WDATA_I[FC_TERMSEL_BIT];
      xcvr_sel_reg <= REG_WDATA_I[FC_XCVRSEL_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      otg_ctrl_reg <= 8'h00;
    end else if (wr_hit(OFS_OTG_CTRL)) begin
      otg_ctrl_reg <= REG_WDATA_I[7:0] & OC_WRITABLE;
    end
  end

  // sample otg status and rx lines
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      otg_flags_reg <= 6'h00;
      rx_lines_reg <= 3'h0;
    end else begin
      otg_flags_reg <= {PHY_STATUS_I.bvalid, PHY_STATUS_I.id_gnd, PHY_STATUS_I.host_disc,
                        PHY_STATUS_I.vbus_valid, PHY_STATUS_I.sess_valid,
                        PHY_STATUS_I.sess_end};
      rx_lines_reg <= {PHY_STATUS_I.rx_rcv, PHY_STATUS_I.rx_dm, PHY_STATUS_I.rx_dp};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      tx_se0_reg <= 1'b0;
      tx_data_reg <= 1'b0;
      tx_en_n_reg <= SC_TX_EN_N_RST;
      fsls_reg <= 1'b0;
    end else if (wr_hit(OFS_SERIAL_CTRL)) begin
      tx_se0_reg <= REG_WDATA_I[SC_TX_SE0];
      tx_data_reg <= REG_WDATA_I[SC_TX_DATA];
      tx_en_n_reg <= REG_WDATA_I[SC_TX_EN_N];
      fsls_reg <= REG_WDATA_I[SC_FSLS_SERIAL];
    end
  end

  // device address, sticky, masks, endpoint marks, otg mask
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      dev_addr_reg <= 7'h00;
      sticky_reg <= 7'h00;
      port_masks_reg <= 32'h0000_0000;
      ep_mark_reg <= 16'h0000;
      otg_mask_reg <= 32'h0000_0000;
    end else begin
      if (wr_hit(OFS_DEV_ADDR)) begin
        dev_addr_reg <= REG_WDATA_I[6:0];
      end
      if (wr_hit(OFS_STICKY)) begin
        sticky_reg <= REG_WDATA_I[6:0];
      end
      if (wr_hit(OFS_PORT_MASKS)) begin
        port_masks_reg <= REG_WDATA_I;
      end
      if (wr_hit(OFS_EP_MARK)) begin
        ep_mark_reg <= REG_WDATA_I[15:0];
      end
      if (wr_hit(OFS_OTG_MASK)) begin
        otg_mask_reg <= REG_WDATA_I;
      end
    end
  end

  always_comb begin
    flag_set = 7'h00;
    flag_set[EF_TOKEN_OK] = token_match;
    flag_set[EF_SE0] = (PHY_STATUS_I.line_state == LS_SE0);
    flag_set[EF_K] = (PHY_STATUS_I.line_state == LS_K);
    flag_set[EF_J] = (PHY_STATUS_I.line_state == LS_J);
    flag_set[EF_CRC16_ERR] = PKT_INFO_I.data_crc_err;
    flag_follow = 7'h00;
    flag_follow[EF_RX_ACTIVE] = 1'b1;
    flag_follow[EF_RX_ERROR] = 1'b1;
    flag_level = 7'h00;
    flag_level[EF_RX_ACTIVE] = PHY_STATUS_I.rx_active;
    flag_level[EF_RX_ERROR] = PHY_STATUS_I.rx_error;
  end

  genvar gi;
  generate
    for (gi = 0; gi < EF_WIDTH; gi++) begin : g_flag
      usb_flag_bit u_flag (
        .clk_i(CLK_I),
        .rst_n_i(RSTN_I),
        .soft_clr_i(soft_clr),
        .sticky_i(sticky_reg[gi]),
        .pkt_start_i(PKT_INFO_I.pkt_start),
        .set_i(flag_set[gi]),
        .follow_i(flag_follow[gi]),
        .level_i(flag_level[gi]),
        .w1c_i(wr_hit(OFS_EVENT_FLAGS) && REG_WDATA_I[gi]),
        .flag_o(flags[gi])
      );
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || soft_clr) begin
      frame_reg <= 11'h000;
    end else if (wr_hit(OFS_FRAME)) begin
      frame_reg <= REG_WDATA_I[10:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || soft_clr) begin
      pid_reg <= 4'h0;
      ep_reg <= 4'h0;
      ep_valid_reg <= 1'b0;
    end else begin
      if (PKT_INFO_I.pid_valid) begin
        pid_reg <= PKT_INFO_I.pid;
      end
      if (token_match && PKT_INFO_I.ep_valid) begin
        ep_reg <= PKT_INFO_I.endpoint;
        ep_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || soft_clr) begin
      rx_ep_valid_reg <= 1'b0;
      rx_ep_reg <= 5'h00;
    end else begin
      rx_ep_valid_reg <= token_match && PKT_INFO_I.ep_valid;
      if (token_match && PKT_INFO_I.ep_valid) begin
        rx_ep_reg <= ep_mark_reg[PKT_INFO_I.endpoint] ?
                     ({1'b0, PKT_INFO_I.endpoint} | EP_MARK_OR) : {1'b0, PKT_INFO_I.endpoint};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      port_a_reg <= 1'b0;
      port_b_reg <= 1'b0;
      port_c_reg <= 1'b0;
    end else begin
      port_a_reg <= mask_any(port_masks_reg, PM_A_LSB, flags);
      port_b_reg <= mask_any(port_masks_reg, PM_B_LSB, flags);
      port_c_reg <= mask_any(port_masks_reg, PM_C_LSB, flags);
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (REG_ADDR_I)
      OFS_DEV_ADDR: rdata_next[6:0] = dev_addr_reg;
      OFS_FUNC_CTRL: rdata_next[4:0] = {opmode_reg, term_sel_reg, xcvr_sel_reg};
      OFS_OTG_CTRL: rdata_next[7:0] = otg_ctrl_reg;
      OFS_OTG_FLAGS: rdata_next[5:0] = otg_flags_reg;
      OFS_SERIAL_CTRL: rdata_next[6:0] = {rx_lines_reg, tx_se0_reg, tx_data_reg,
                                          tx_en_n_reg, fsls_reg};
      OFS_EVENT_FLAGS: rdata_next[6:0] = flags;
      OFS_STICKY: rdata_next[6:0] = sticky_reg;
      OFS_PORT_MASKS: rdata_next = port_masks_reg;
      OFS_FRAME: rdata_next[10:0] = frame_reg;
      OFS_PID: rdata_next[3:0] = pid_reg;
      OFS_ENDPOINT: rdata_next[4:0] = {ep_valid_reg, ep_reg};
      OFS_EP_MARK: rdata_next[15:0] = ep_mark_reg;
      OFS_OTG_MASK: rdata_next = otg_mask_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      REG_RDATA_O <= 32'h0000_0000;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rdata_next;
      end
    end
  end

  // phy control outputs registered
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      PHY_CTRL_O <= '0;
      PHY_CTRL_O.opmode <= FC_OPMODE_RST;
      PHY_CTRL_O.term_select <= FC_TERMSEL_RST;
      PHY_CTRL_O.xcvr_select <= FC_XCVRSEL_RST;
      PHY_CTRL_O.tx_enable_n <= SC_TX_EN_N_RST;
    end else begin
      PHY_CTRL_O.opmode <= opmode_reg;
      PHY_CTRL_O.term_select <= term_sel_reg;
      PHY_CTRL_O.xcvr_select <= xcvr_sel_reg;
      PHY_CTRL_O.ext_vbus_ind <= otg_ctrl_reg[OC_EXT_VBUS_IND];
      PHY_CTRL_O.ext_vbus_drv <= otg_ctrl_reg[OC_EXT_VBUS_DRV];
      PHY_CTRL_O.chrg_vbus <= otg_ctrl_reg[OC_CHRG_VBUS];
      PHY_CTRL_O.dischrg_vbus <= otg_ctrl_reg[OC_DISCHRG_VBUS];
      PHY_CTRL_O.dm_pulldown <= otg_ctrl_reg[OC_DM_PULLDOWN];
      PHY_CTRL_O.dp_pulldown <= otg_ctrl_reg[OC_DP_PULLDOWN];
      PHY_CTRL_O.id_pullup <= otg_ctrl_reg[OC_ID_PULLUP];
      PHY_CTRL_O.tx_se0 <= tx_se0_reg;
      PHY_CTRL_O.tx_data <= tx_data_reg;
      PHY_CTRL_O.tx_enable_n <= tx_en_n_reg;
      PHY_CTRL_O.fsls_serial <= fsls_reg;
    end
  end

  assign FLAG_OUTPUT_PORT_A_O = port_a_reg;
  assign FLAG_OUTPUT_PORT_B_O = port_b_reg;
  assign FLAG_OUTPUT_PORT_C_O = port_c_reg;
  assign RX_EP_VALID_O = rx_ep_valid_reg;
  assign RX_EP_O = rx_ep_reg;
endmodule
`default_nettype wire

// ### tb/usb_ifm_regs_props.sv
// concurrent checks on the register block ports
`timescale 1ns/1ps
`default_nettype none
module usb_ifm_regs_props (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire usb_ifm_pkg::phy_status_t PHY_STATUS_I,
  input wire usb_ifm_pkg::pkt_info_t PKT_INFO_I,
  input wire usb_ifm_pkg::phy_ctrl_t PHY_CTRL_O,
  input wire logic RX_EP_VALID_O,
  input wire logic [4:0] RX_EP_O
);
  import usb_ifm_pkg::*;
  logic [31:0] wd1;
  logic [31:0] wd2;
  phy_status_t st1;
  phy_status_t st2;
  pkt_info_t pk1;
  always_ff @(posedge CLK_I) begin
    wd1 <= REG_WDATA_I;
    wd2 <= wd1;
    st1 <= PHY_STATUS_I;
    st2 <= st1;
    pk1 <= PKT_INFO_I;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_opmode_drive: assert property (REG_WR_I && REG_ADDR_I == OFS_FUNC_CTRL
    |=> ##1 PHY_CTRL_O.opmode == wd2[4:2]) else $error("opmode not driven");
  a_term_xcvr: assert property (REG_WR_I && REG_ADDR_I == OFS_FUNC_CTRL
    |=> ##1 {PHY_CTRL_O.term_select, PHY_CTRL_O.xcvr_select} == wd2[1:0])
    else $error("term or xcvr select not driven");
  a_otg_drive: assert property (REG_WR_I && REG_ADDR_I == OFS_OTG_CTRL
    |=> ##1 PHY_CTRL_O[10:4] == {wd2[7:6], wd2[4:0]}) else $error("otg controls wrong");
  a_serial_drive: assert property (REG_WR_I && REG_ADDR_I == OFS_SERIAL_CTRL
    |=> ##1 PHY_CTRL_O[3:0] == wd2[3:0]) else $error("serial tx controls wrong");
  a_otg_read: assert property (REG_RD_I && REG_ADDR_I == OFS_OTG_FLAGS
    |=> REG_RVALID_O && REG_RDATA_O == {26'h0, st2[12:7]}) else $error("otg flags read wrong");
  a_rx_read: assert property (REG_RD_I && REG_ADDR_I == OFS_SERIAL_CTRL
    |=> REG_RDATA_O[31:4] == {25'h0, st2[6:4]}) else $error("rx lines read wrong");
  a_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I > OFS_OTG_MASK
    |=> REG_RDATA_O == 32'h0) else $error("unmapped read not zero");
  a_ep_present: assert property (RX_EP_VALID_O
    |-> pk1.token_valid && pk1.ep_valid && RX_EP_O[3:0] == pk1.endpoint)
    else $error("rx endpoint without token");
  a_reset_ctrl: assert property ($rose(RSTN_I) |-> PHY_CTRL_O == 16'h3802)
    else $error("phy controls not at reset value");
endmodule
bind usb_ifm_regs usb_ifm_regs_props props (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .PHY_STATUS_I(PHY_STATUS_I), .PKT_INFO_I(PKT_INFO_I), .PHY_CTRL_O(PHY_CTRL_O),
  .RX_EP_VALID_O(RX_EP_VALID_O), .RX_EP_O(RX_EP_O));
`default_nettype wire

// ### tb/usb_phy_model.sv
// behavioural utmi phy and packet decoder facing the register block
`timescale 1ns/1ps
`default_nettype none
module usb_phy_model (
  input wire logic clk_i,
  input wire usb_ifm_pkg::phy_ctrl_t ctrl_i,
  output var usb_ifm_pkg::phy_status_t status_o,
  output var usb_ifm_pkg::pkt_info_t pkt_o
);
  import usb_ifm_pkg::*;
  initial begin
    status_o = '0;
    status_o.line_state = 2'h3;
    pkt_o = '0;
  end
  // transmitter looped back onto the receive lines, quiet when disabled
  always @(posedge clk_i) begin
    #1;
    status_o.rx_rcv = !ctrl_i.tx_enable_n && ctrl_i.tx_data && !ctrl_i.tx_se0;
    status_o.rx_dp = !ctrl_i.tx_enable_n && ctrl_i.tx_data && !ctrl_i.tx_se0;
    status_o.rx_dm = !ctrl_i.tx_enable_n && !ctrl_i.tx_data && !ctrl_i.tx_se0;
  end
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask
  task automatic set_otg(input logic [5:0] v);
    step;
    status_o[12:7] = v;
  endtask
  task automatic line(input logic [1:0] ls);
    step;
    status_o.line_state = ls;
  endtask
  task automatic rx(input logic [1:0] v);
    step;
    {status_o.rx_active, status_o.rx_error} = v;
  endtask
  task automatic pulse_start;
    step;
    pkt_o.pkt_start = 1'b1;
    step;
    pkt_o = '0;
  endtask
  task automatic crc_err;
    step;
    pkt_o.data_crc_err = 1'b1;
    step;
    pkt_o = '0;
  endtask
  task automatic token(input logic [6:0] a, input logic [3:0] e, input logic [3:0] p);
    step;
    pkt_o.pkt_start = 1'b1;
    step;
    pkt_o = {1'b0, 1'b1, a, 1'b0, 1'b1, p, 1'b1, e};
    step;
    pkt_o = '0;
  endtask
endmodule
`default_nettype wire

// ### tb/usb_ifm_regs_tb.sv
// self-checking bench for the usb interface machine register set
`timescale 1ns/1ps
`default_nettype none
module usb_ifm_regs_tb;
  import usb_ifm_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, rvalid, pa, pb, pc, epv;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [4:0] ep, ep_seen = '0;
  logic [6:0] da;
  logic [3:0] e;
  phy_status_t st;
  pkt_info_t pk;
  phy_ctrl_t ctrl;
  logic [31:0] expq[$];
  string nq[$];
  int n_errors = 0, tests_run = 0, cyc = 0, epn = 0;
  logic [7:0] ofs[14] = '{8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28, 8'h34, 8'h38,
    8'h14, 8'h2c, 8'h30, 8'h1c, 8'h3c};
  logic [31:0] rs[14] = '{0, 7, 0, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [31:0] msk[14] = '{32'h7f, 32'h1f, 32'hdf, 32'h0f, 32'h7f, '1, 32'h7ff, 32'hffff,
    '1, 0, 0, 0, 0, 0};
  logic [1:0] lc[3] = '{LS_SE0, LS_K, LS_J};
  always #4 clk = ~clk;
  usb_ifm_regs dut (.CLK_I(clk), .RSTN_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .PHY_STATUS_I(st), .PKT_INFO_I(pk), .PHY_CTRL_O(ctrl), .FLAG_OUTPUT_PORT_A_O(pa),
    .FLAG_OUTPUT_PORT_B_O(pb), .FLAG_OUTPUT_PORT_C_O(pc), .RX_EP_VALID_O(epv),
    .RX_EP_O(ep));
  usb_phy_model phy (.clk_i(clk), .ctrl_i(ctrl), .status_o(st), .pkt_o(pk));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] a);
    tests_run++;
    if (a !== x) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, x, a);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 wr = 1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 0;
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] x, input string nm);
    @(posedge clk);
    #1 rd = 1;
    addr = a;
    expq.push_back(x);
    nq.push_back(nm);
    @(posedge clk);
    #1 rd = 0;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) if (rvalid === 1'b1 && expq.size() > 0) begin
    chk(nq.pop_front(), expq.pop_front(), rdata);
  end
  always @(posedge clk) if (epv === 1'b1) begin
    ep_seen <= ep;
    epn++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(25071));
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    chk("ctrl", 32'h3802, {16'h0, ctrl});
    foreach (ofs[i]) r(ofs[i], rs[i], "reset");
    $display("reset values done");
    foreach (ofs[i]) begin
      v = $urandom | 32'h2;
      w(ofs[i], v);
      r(ofs[i], v & msk[i] | rs[i] & ~msk[i], "rw");
    end
    w(8'h0c, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("opmode", {29'h0, OPMODE_DISABLED}, {29'h0, ctrl.opmode});
    $display("access test done");
    v = $urandom;
    phy.set_otg(v[5:0]);
    r(8'h14, {26'h0, v[5:0]}, "otg");
    w(8'h18, 32'h4);
    // loopback reaches the rx lines only after the registered control output
    repeat (2) @(posedge clk);
    r(8'h18, 32'h54, "serial");
    w(8'h18, 32'h2);
    $display("phy status done");
    w(8'h20, 0);
    w(8'h24, 32'h00400220);
    foreach (lc[k]) begin
      phy.pulse_start;
      phy.line(lc[k]);
      phy.line(2'h3);
      r(8'h1c, 32'h20 >> k, "line");
      chk("porta", k == 0, pa);
    end
    phy.rx(2'b11);
    r(8'h1c, 32'h0b, "follow");
    chk("portb", 1, pb);
    w(8'h20, 32'h7f);
    phy.rx(2'b00);
    phy.pulse_start;
    r(8'h1c, 32'h0b, "sticky");
    w(8'h1c, 32'h3);
    r(8'h1c, 32'h08, "clear1");
    w(8'h20, 0);
    phy.pulse_start;
    r(8'h1c, 0, "autoclr");
    $display("flag test done");
    da = 7'($urandom);
    e = 4'($urandom);
    w(8'h08, {25'h0, da});
    w(8'h34, 32'h1 << e);
    phy.token(da ^ 7'h1, e, 4'hd);
    r(8'h1c, 0, "badaddr");
    chk("epcnt", 0, epn);
    phy.token(da, e, 4'h9);
    r(8'h1c, 32'h40, "token");
    chk("portc", 1, pc);
    chk("rxep", {27'h0, 1'b1, e}, {27'h0, ep_seen});
    r(8'h2c, 32'h9, "pid");
    r(8'h30, {27'h0, 1'b1, e}, "ep");
    phy.token(da, e + 4'h1, 4'h1);
    phy.crc_err;
    r(8'h1c, 32'h44, "crc");
    chk("rxep2", {28'h0, e + 4'h1}, {27'h0, ep_seen});
    w(8'h28, 32'h5a5);
    w(8'h00, $urandom);
    r(8'h28, 0, "sof");
    r(8'h2c, 0, "pid0");
    r(8'h30, 0, "ep0");
    chk("rxep0", 0, {27'h0, ep});
    $display("packet test done");
    repeat (4) @(posedge clk);
    chk("pending", 0, expq.size());
    finish_test;
  end
endmodule
`default_nettype wire
